/* rtl/nfca_tag_regs.vh */
// Register map, command codes and answer codes of the NFC-A tag core.
`ifndef NFCA_TAG_REGS_VH
`define NFCA_TAG_REGS_VH

// ==========================================================
// Register byte offsets on the APB port.
`define OFF_CTRL      8'h00
`define OFF_PASSWORD_PROTECTION_CONFIG  8'h04
`define OFF_PROTECTED_AREA_LIMIT  8'h08
`define OFF_AUTH_FAILURE_COUNTER  8'h0C
`define OFF_PASSWORD  8'h10
`define OFF_WAKE_EN   8'h14
`define OFF_STATUS    8'h18

// ==========================================================
// Control register fields.
`define CTRL_SILENT   0
`define CTRL_KILL_TUN 1
`define CTRL_KILL_RF  2
`define CTRL_TUNNEL   3
`define CTRL_SET_DEF  8
`define CTRL_GO_SENSE 9
`define CTRL_GO_SLEEP 10

// Protection config fields.
`define CFG_RD_PROT   0
`define CFG_WR_PROT   1

// Wake enable fields.
`define WAKE_PUP      0
`define WAKE_SEL      1
`define WAKE_SLP      2
`define WAKE_MEM      3

// ==========================================================
// Reset values.
`define RST_CTRL      4'h0
`define RST_CFG       2'h0
`define RST_LIM       8'hFF
`define RST_PWD       32'hFFFF_FFFF
`define RST_WAKE      4'h0

// Failure count that locks the tag.
`define AUTH_MAX      3'h7

// ==========================================================
// Decoded RF commands from the frame receiver.
`define CMD_SENS_REQ  4'h0
`define CMD_ALL_REQ   4'h1
`define CMD_SDD_REQ   4'h2
`define CMD_SEL_REQ   4'h3
`define CMD_SLP_REQ   4'h4
`define CMD_READ      4'h5
`define CMD_WRITE     4'h6
`define CMD_SECT_SEL  4'h7

// Answer kinds toward the frame transmitter.
`define RSP_SENS_RES  3'h1
`define RSP_UID       3'h2
`define RSP_SEL_RES   3'h3
`define RSP_ACKNAK    3'h4
`define RSP_DATA      3'h5

// Four-bit acknowledge codes.
`define CODE_ACK      4'hA
`define CODE_NAK      4'h0

`endif

/* rtl/nfca_tag_state_machine.v */
// Tag-side NFC-A protocol state machine with APB register port.
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ns
`include "nfca_tag_regs.vh"

module nfca_tag_state_machine #(
    parameter MEM_BLOCKS = 8'h30,  // Blocks inside the memory.
    parameter PWD_BLOCK  = 8'h2B   // Password block address.
) (
    input  wire        clk,
    input  wire        rst,
    // APB slave.
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Decoded reader frames.
    input  wire        cmd_valid,
    input  wire [3:0]  cmd_code,
    input  wire        cmd_level,
    input  wire        cmd_uid_match,
    input  wire [7:0]  cmd_addr,
    input  wire [31:0] cmd_data,
    // Supply comparator pin, high when host supply is low.
    input  wire        host_supply_pin,
    // Answers toward the transmitter.
    output reg         rsp_valid,
    output reg  [2:0]  rsp_kind,
    output reg  [3:0]  rsp_code,
    output reg         rsp_level,
    // Memory requests from the reader side.
    output reg         mem_rd,
    output reg         mem_wr,
    output reg  [7:0]  mem_addr,
    output reg  [31:0] mem_wdata,
    output reg         tunnel_active,
    output reg         rf_enabled,
    output reg         wake
);

    // ======================================================
    // State codes.
    localparam [2:0] ST_SENSE = 3'h0;
    localparam [2:0] ST_SLEEP = 3'h1;
    localparam [2:0] ST_RES1  = 3'h2;
    localparam [2:0] ST_RES2  = 3'h3;
    localparam [2:0] ST_SEL   = 3'h4;
    localparam [2:0] ST_AUTH  = 3'h5;

    // ======================================================
    // Registers.
    reg  [2:0]  state_r;         // Protocol state.
    reg         sleep_flag_r;    // Remembered waiting state.
    reg  [3:0]  ctrl_r;          // Silent, kill and tunnel bits.
    reg  [1:0]  password_protection_config_r; // Read/write.
    reg  [7:0]  protected_area_limit_r; // First protected block.
    reg  [2:0]  auth_failure_counter_r; // Failed attempts.
    reg  [31:0] password_r;      // Current password.
    reg  [3:0]  wake_en_r;       // Wake event enables.
    reg         pup_done_r;      // Power-up event issued.
    reg  [2:0]  sup_sync_r;      // Supply pin synchroniser.
    reg         supply_low_r;    // Filtered supply level.

    wire        locked;          // Lock sub-state.
    wire        rf_off;          // RF muted by silent or kill.
    wire        wait_state;      // Tag sits in SENSE or SLEEP.
    wire [2:0]  home;            // Return target.
    wire        apb_wr;          // APB write takes effect.

    assign locked = (auth_failure_counter_r == `AUTH_MAX);
    // Silent mode only bites while the supply is low.
    assign rf_off = (ctrl_r[`CTRL_SILENT] & supply_low_r)
                  | ctrl_r[`CTRL_KILL_RF];
    assign wait_state = (state_r == ST_SENSE)
                      | (state_r == ST_SLEEP);
    assign home = sleep_flag_r ? ST_SLEEP : ST_SENSE;
    assign apb_wr = psel & penable & pready & pwrite;

    // ======================================================
    // Access check for reader accesses. Host accesses never
    // pass here, so protection cannot block them.
    function denied;
        input [7:0] addr;
        input       prot;
        input       authd;
        input       tun;
        begin
            // Out of range only passes when tunnelling.
            denied = ((addr >= MEM_BLOCKS) & ~tun)
                   | ((addr >= protected_area_limit_r)
                      & prot & ~authd);
        end
    endfunction

    // ======================================================
    // Supply pin synchroniser. The level moves only once the
    // second and third stages agree, which also filters out
    // single-cycle glitches from the comparator.
    always @(posedge clk) begin
        if (rst) begin
            sup_sync_r   <= 3'h0;
            supply_low_r <= 1'b0;
        end else begin
            sup_sync_r <= {sup_sync_r[1:0], host_supply_pin};
            if (sup_sync_r[1] == sup_sync_r[2]) begin
                supply_low_r <= sup_sync_r[2];
            end
        end
    end

    // ======================================================
    // APB answer: one wait state, then a registered reply.
    // Unmapped offsets read zero and flag an error.
    always @(posedge clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel & penable & ~pready) begin
                case (paddr)
                    `OFF_CTRL: begin
                        prdata <= {28'h000_0000, ctrl_r};
                    end
                    `OFF_PASSWORD_PROTECTION_CONFIG: begin
                        prdata <= {30'h0000_0000,
                                   password_protection_config_r};
                    end
                    `OFF_PROTECTED_AREA_LIMIT: begin
                        prdata <= {24'h00_0000,
                                   protected_area_limit_r};
                    end
                    `OFF_AUTH_FAILURE_COUNTER: begin
                        prdata <= {29'h0000_0000,
                                   auth_failure_counter_r};
                    end
                    `OFF_PASSWORD: begin
                        prdata <= password_r;
                    end
                    `OFF_WAKE_EN: begin
                        prdata <= {28'h000_0000, wake_en_r};
                    end
                    `OFF_STATUS: begin
                        prdata <= {26'h000_0000, rf_off, locked,
                                   sleep_flag_r, state_r};
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ======================================================
    // Protocol engine and register writes. Both sides can
    // change the counter and the password, so they share one
    // process; a reader event in the same cycle as a host
    // write wins, so no failed attempt is ever lost.
    always @(posedge clk) begin
        if (rst) begin
            state_r       <= ST_SENSE;
            sleep_flag_r  <= 1'b0;
            ctrl_r        <= `RST_CTRL;
            password_protection_config_r <= `RST_CFG;
            protected_area_limit_r <= `RST_LIM;
            auth_failure_counter_r <= 3'h0;
            password_r    <= `RST_PWD;
            wake_en_r     <= `RST_WAKE;
            pup_done_r    <= 1'b0;
            rsp_valid     <= 1'b0;
            rsp_kind      <= 3'h0;
            rsp_code      <= `CODE_NAK;
            rsp_level     <= 1'b0;
            mem_rd        <= 1'b0;
            mem_wr        <= 1'b0;
            mem_addr      <= 8'h00;
            mem_wdata     <= 32'h0000_0000;
            tunnel_active <= 1'b0;
            rf_enabled    <= 1'b0;
            wake          <= 1'b0;
        end else begin
            rsp_valid  <= 1'b0;
            mem_rd     <= 1'b0;
            mem_wr     <= 1'b0;
            pup_done_r <= 1'b1;
            wake       <= ~pup_done_r & wake_en_r[`WAKE_PUP];
            rf_enabled <= ~rf_off;
            // Tunnelling is blocked while the kill bit is set.
            tunnel_active <= ctrl_r[`CTRL_TUNNEL]
                           & ~ctrl_r[`CTRL_KILL_TUN];

            // Host writes; only this port reaches kill bits.
            if (apb_wr) begin
                case (paddr)
                    `OFF_CTRL: begin
                        ctrl_r <= pwdata[3:0];
                        // Lock release needs a counter below AUTH_MAX.
                        if ((pwdata[`CTRL_SET_DEF]
                             | pwdata[`CTRL_GO_SENSE])
                            & ~locked) begin
                            state_r      <= ST_SENSE;
                            sleep_flag_r <= 1'b0;
                        end else if (pwdata[`CTRL_GO_SLEEP]
                                     & ~locked) begin
                            state_r      <= ST_SLEEP;
                            sleep_flag_r <= 1'b1;
                        end
                    end
                    `OFF_PASSWORD_PROTECTION_CONFIG: begin
                        password_protection_config_r <=
                            pwdata[1:0];
                    end
                    `OFF_PROTECTED_AREA_LIMIT: begin
                        protected_area_limit_r <= pwdata[7:0];
                    end
                    `OFF_AUTH_FAILURE_COUNTER: begin
                        auth_failure_counter_r <= pwdata[2:0];
                    end
                    `OFF_PASSWORD: begin
                        password_r <= pwdata;
                    end
                    `OFF_WAKE_EN: begin
                        wake_en_r <= pwdata[3:0];
                    end
                    default: begin
                        wake_en_r <= wake_en_r;
                    end
                endcase
            end

            if (rf_off) begin
                // Muted: drop to waiting, never answer.
                if (~wait_state) begin
                    state_r <= home;
                end
            end else if (cmd_valid) begin
                rsp_level <= cmd_level;
                case (state_r)
                    ST_SENSE: begin
                        // Only the two wake-up requests count.
                        if ((cmd_code == `CMD_SENS_REQ)
                            | (cmd_code == `CMD_ALL_REQ)) begin
                            state_r   <= ST_RES1;
                            rsp_valid <= 1'b1;
                            rsp_kind  <= `RSP_SENS_RES;
                        end
                    end
                    ST_SLEEP: begin
                        if (cmd_code == `CMD_ALL_REQ) begin
                            state_r   <= ST_RES1;
                            rsp_valid <= 1'b1;
                            rsp_kind  <= `RSP_SENS_RES;
                        end
                    end
                    ST_RES1, ST_RES2: begin
                        // Level 1 first, then level 2.
                        if ((cmd_code == `CMD_SDD_REQ)
                            & (cmd_level == (state_r == ST_RES2))) begin
                            rsp_valid <= 1'b1;
                            rsp_kind  <= `RSP_UID;
                        end else if ((cmd_code == `CMD_SEL_REQ)
                            & cmd_uid_match
                            & (cmd_level == (state_r == ST_RES2))) begin
                            rsp_valid <= 1'b1;
                            rsp_kind  <= `RSP_SEL_RES;
                            if (state_r == ST_RES1) begin
                                state_r <= ST_RES2;
                            end else begin
                                state_r <= ST_SEL;
                                wake <= wake_en_r[`WAKE_SEL];
                            end
                        end else begin
                            state_r <= home;
                        end
                    end
                    ST_SEL, ST_AUTH: begin
                        rsp_valid <= 1'b1;
                        rsp_kind  <= `RSP_ACKNAK;
                        rsp_code  <= `CODE_NAK;
                        case (cmd_code)
                            `CMD_SLP_REQ: begin
                                // No answer to a sleep request.
                                rsp_valid    <= 1'b0;
                                state_r      <= ST_SLEEP;
                                sleep_flag_r <= 1'b1;
                                wake <= wake_en_r[`WAKE_SLP];
                            end
                            `CMD_SECT_SEL: begin
                                state_r <= home;
                            end
                            `CMD_READ: begin
                                // Read protection bit.
                                if (denied(cmd_addr,
                                    password_protection_config_r
                                        [`CFG_RD_PROT],
                                    state_r == ST_AUTH,
                                    tunnel_active)) begin
                                    rsp_code <= `CODE_NAK;
                                end else begin
                                    rsp_valid <= 1'b0;
                                    mem_rd    <= 1'b1;
                                    mem_addr  <= cmd_addr;
                                end
                            end
                            `CMD_WRITE: begin
                                if (cmd_addr == PWD_BLOCK) begin
                                    if (state_r == ST_AUTH) begin
                                        password_r <= cmd_data;
                                        rsp_code <= `CODE_ACK;
                                    end else if (locked) begin
                                        // Further guesses refused.
                                        rsp_code <= `CODE_NAK;
                                    end else if (cmd_data
                                        == password_r) begin
                                        state_r  <= ST_AUTH;
                                        rsp_code <= `CODE_ACK;
                                    end else begin
                                        auth_failure_counter_r <=
                                            auth_failure_counter_r
                                            + 3'h1;
                                    end
                                end else if (denied(cmd_addr,
                                    password_protection_config_r
                                        [`CFG_WR_PROT],
                                    state_r == ST_AUTH,
                                    tunnel_active)) begin
                                    rsp_code <= `CODE_NAK;
                                end else begin
                                    mem_wr    <= 1'b1;
                                    mem_addr  <= cmd_addr;
                                    mem_wdata <= cmd_data;
                                    rsp_code  <= `CODE_ACK;
                                    wake <= wake_en_r[`WAKE_MEM];
                                end
                            end
                            default: begin
                                // Unsupported: silent return.
                                rsp_valid <= 1'b0;
                                state_r   <= home;
                            end
                        endcase
                    end
                    default: begin
                        state_r <= ST_SENSE;
                    end
                endcase
            end
        end
    end

endmodule // nfca_tag_state_machine

/* bench/nfca_tag_state_machine_sva.sv */
// Port-level assertions for the NFC-A tag state machine.
`timescale 1ns/1ns
`include "nfca_tag_regs.vh"
module nfca_tag_state_machine_sva #(
    parameter MEM_BLOCKS = 8'h30  // Blocks inside the memory.
) (
    input wire        clk,
    input wire        rst,
    input wire        psel,
    input wire        penable,
    input wire [7:0]  paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        cmd_valid,
    input wire [3:0]  cmd_code,
    input wire        cmd_level,
    input wire [7:0]  cmd_addr,
    input wire        rsp_valid,
    input wire [2:0]  rsp_kind,
    input wire [3:0]  rsp_code,
    input wire        rsp_level,
    input wire        mem_rd,
    input wire        mem_wr,
    input wire [7:0]  mem_addr,
    input wire        tunnel_active,
    input wire        rf_enabled,
    input wire        wake
);
    // ==========================================================
    // All checks share one clock and the synchronous reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_apb_wait: assert property (psel && penable && !pready |=> pready)
        else $error("register access not answered after one wait");
    a_bad_offset: assert property (pready |-> pslverr ==
        (paddr > `OFF_STATUS || paddr[1:0] != 2'b00))
        else $error("error flag does not match the offset");
    a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    a_ans_cause: assert property ((rsp_valid || mem_rd || mem_wr)
        |-> $past(cmd_valid))
        else $error("answer without a reader frame");
    // Two low samples cover the one-cycle lag of the flag.
    a_mute_quiet: assert property (!rf_enabled && !$past(rf_enabled)
        |-> !(rsp_valid || mem_rd || mem_wr))
        else $error("muted tag answered");
    a_mem_range: assert property ((mem_rd || mem_wr) |-> mem_addr <
        MEM_BLOCKS || tunnel_active || $past(tunnel_active))
        else $error("memory access outside the array");
    a_mem_cmd: assert property (mem_rd |-> $past(cmd_code) ==
        `CMD_READ && mem_addr == $past(cmd_addr))
        else $error("memory read not caused by a read frame");
    a_sector_nak: assert property (rsp_valid && $past(cmd_code) ==
        `CMD_SECT_SEL |-> rsp_kind == `RSP_ACKNAK && rsp_code == `CODE_NAK)
        else $error("sector select not refused");
    a_sense_cause: assert property (rsp_valid && rsp_kind ==
        `RSP_SENS_RES |-> $past(cmd_code) inside {`CMD_SENS_REQ, `CMD_ALL_REQ})
        else $error("wake answer to a wrong frame");
    a_sleep_mute: assert property ($past(cmd_valid) &&
        $past(cmd_code) == `CMD_SLP_REQ |-> !rsp_valid)
        else $error("answer given to a sleep request");
    a_level_echo: assert property (rsp_valid && (rsp_kind == `RSP_UID ||
        rsp_kind == `RSP_SEL_RES) |-> rsp_level == $past(cmd_level))
        else $error("cascade level not echoed");
    c_level_two: cover property (rsp_valid && rsp_kind == `RSP_SEL_RES && rsp_level);
    c_mem_write: cover property (mem_wr);
    c_wake: cover property (wake);
endmodule // nfca_tag_state_machine_sva

bind nfca_tag_state_machine nfca_tag_state_machine_sva #(
    .MEM_BLOCKS(MEM_BLOCKS)) chk_i (.*);

/* bench/nfca_reader.sv */
// Reader model that hands decoded frames to the tag.
`timescale 1ns/1ns
module nfca_reader (
    input  wire        clk,
    output reg         cmd_valid,
    output reg  [3:0]  cmd_code,
    output reg         cmd_level,
    output reg         cmd_uid_match,
    output reg  [7:0]  cmd_addr,
    output reg  [31:0] cmd_data
);
    // Idle at time zero so no frame is seen during reset.
    initial begin
        {cmd_valid, cmd_code, cmd_level} = 6'h0;
        {cmd_uid_match, cmd_addr, cmd_data} = 41'h0;
    end
    // One-cycle frame; address and data are inverted afterwards so a design that
    // reads them outside the strobe sees garbage, not a stale match.
    task send(input [3:0] c, input l, input m, input [7:0] a,
              input [31:0] d);
        begin
            @(posedge clk);
            cmd_valid <= 1'b1;
            {cmd_code, cmd_level, cmd_uid_match} <= {c, l, m};
            {cmd_addr, cmd_data} <= {a, d};
            @(posedge clk);
            cmd_valid <= 1'b0;
            {cmd_addr, cmd_data} <= ~{a, d};
        end
    endtask
endmodule // nfca_reader

/* bench/nfca_tag_state_machine_tb.sv */
// Self-checking bench for the NFC-A tag state machine.
`timescale 1ns/1ns
`include "nfca_tag_regs.vh"
module nfca_tag_state_machine_tb;
    // ==========================================================
    // Answer patterns: valid, kind, code, mem_rd, mem_wr.
    localparam [9:0] NONE = 10'h0;
    localparam [9:0] SRES = {1'b1, `RSP_SENS_RES, 6'h0};
    localparam [9:0] ACK  = {1'b1, `RSP_ACKNAK, `CODE_ACK, 2'b00};
    localparam [9:0] NAK  = {1'b1, `RSP_ACKNAK, `CODE_NAK, 2'b00};
    localparam [7:0] PWB  = 8'h2B;  // Password block.
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [7:0]  paddr = 8'h0;
    reg  [31:0] pwdata = 32'h0;
    reg         host_supply_pin = 1'b0;
    wire [31:0] prdata, mem_wdata, cmd_data;
    wire        pready, pslverr, rsp_valid, rsp_level, mem_rd, mem_wr;
    wire        tunnel_active, rf_enabled, wake, cmd_valid, cmd_level;
    wire        cmd_uid_match;
    wire [2:0]  rsp_kind;
    wire [3:0]  rsp_code, cmd_code;
    wire [7:0]  mem_addr, cmd_addr;
    integer     errors = 0, tests_run = 0, wakes = 0, n, i;
    reg  [31:0] rd;
    reg         serr;

    always #10 clk = ~clk;
    // Counts wake pulses so events can be checked after the fact.
    always @(posedge clk) if (wake) wakes <= wakes + 1;

    nfca_tag_state_machine uut (.*);
    nfca_reader rdr (.*);

    // ==========================================================
    // Comparison, bus and frame tasks.
    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("ERROR %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    // APB transfer; the request holds until pready is sampled high.
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
            @(posedge clk);
            penable <= 1'b1;
            i = 0;
            @(posedge clk);
            while (pready !== 1'b1 && i < 8) begin
                @(posedge clk);
                i = i + 1;
            end
            if (pready !== 1'b1) begin
                errors = errors + 1;
                conclude;
            end
            {rd, serr} = {prdata, pslverr};
            {psel, penable} <= 2'b00;
        end
    endtask
    task fr(input [3:0] c, input l, input [7:0] a, input [31:0] d,
            input [9:0] e);
        begin
            rdr.send(c, l, 1'b1, a, d);
            #1;
            chk({22'h0, rsp_valid, rsp_valid ? rsp_kind : 3'h0,
                 (rsp_valid && rsp_kind == `RSP_ACKNAK) ? rsp_code : 4'h0,
                 mem_rd, mem_wr}, {22'h0, e});
        end
    endtask
    task f(input [3:0] c, input [9:0] e);
        fr(c, 1'b0, 8'h0, 32'h0, e);
    endtask
    // Wake frame, then both cascade levels of resolution.
    task sel(input [3:0] c);
        begin
            f(c, SRES);
            for (n = 0; n < 4; n = n + 1)
                fr(n[0] ? `CMD_SEL_REQ : `CMD_SDD_REQ, n[1], 8'h0, 32'h0,
                   {1'b1, n[0] ? `RSP_SEL_RES : `RSP_UID, 6'h0});
        end
    endtask
    // Strobes only; after a refused access, drop to waiting with a bad frame and reselect.
    task fm(input [3:0] c, input [7:0] a, input [1:0] e);
        begin
            rdr.send(c, 1'b0, 1'b1, a, 32'h0);
            #1;
            chk({30'h0, mem_rd, mem_wr}, {30'h0, e});
            if (e == 2'b00) begin
                f(4'hF, NONE);
                sel(`CMD_ALL_REQ);
            end
        end
    endtask
    task conclude;
        begin
            $display("Comparisons %0d, mismatches %0d", tests_run, errors);
            if (errors == 0 && tests_run > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    // ==========================================================
    // Main sequence.
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(rd[5:0], 6'h00);
        apb(1'b0, 8'h1C, 32'h0);
        chk({serr, rd}, {1'b1, 32'h0});
        fm(`CMD_READ, 8'h04, 2'b00);
        f(`CMD_SDD_REQ, NONE);
        sel(`CMD_SENS_REQ);
        fm(`CMD_READ, 8'h2F, 2'b10);
        fm(`CMD_READ, 8'h30, 2'b00);
        f(4'hE, NONE);
        sel(`CMD_SENS_REQ);
        f(`CMD_SECT_SEL, NAK);
        sel(`CMD_SENS_REQ);
        f(`CMD_SLP_REQ, NONE);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(rd[3], 1'b1);
        f(`CMD_SENS_REQ, NONE);
        sel(`CMD_ALL_REQ);
        f(4'hF, NONE);
        f(`CMD_SENS_REQ, NONE);
        sel(`CMD_ALL_REQ);
        apb(1'b1, `OFF_PASSWORD_PROTECTION_CONFIG, 32'h0000_0001);
        apb(1'b1, `OFF_PROTECTED_AREA_LIMIT, 32'h0000_0010);
        fm(`CMD_READ, 8'h20, 2'b00);
        fm(`CMD_WRITE, 8'h20, 2'b01);
        chk(mem_addr, 8'h20);
        apb(1'b1, `OFF_PASSWORD_PROTECTION_CONFIG, 32'h0000_0003);
        fm(`CMD_WRITE, 8'h20, 2'b00);
        fr(`CMD_WRITE, 1'b0, PWB, 32'h1234_5678, NAK);
        fr(`CMD_WRITE, 1'b0, PWB, 32'hFFFF_FFFF, ACK);
        fm(`CMD_READ, 8'h20, 2'b10);
        fr(`CMD_WRITE, 1'b0, PWB, 32'hA5A5_0001, ACK);
        apb(1'b0, `OFF_PASSWORD, 32'h0);
        chk(rd, 32'hA5A5_0001);
        apb(1'b1, `OFF_AUTH_FAILURE_COUNTER, 32'h0);
        f(4'hF, NONE);
        sel(`CMD_ALL_REQ);
        repeat (7) fr(`CMD_WRITE, 1'b0, PWB, 32'h0, NAK);
        apb(1'b0, `OFF_AUTH_FAILURE_COUNTER, 32'h0);
        chk(rd, 32'h0000_0007);
        fr(`CMD_WRITE, 1'b0, PWB, 32'hA5A5_0001, NAK);
        fm(`CMD_READ, 8'h04, 2'b10);
        fm(`CMD_READ, 8'h20, 2'b00);
        apb(1'b1, `OFF_CTRL, 32'h0000_0200);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(rd[4], 1'b1);
        apb(1'b1, `OFF_AUTH_FAILURE_COUNTER, 32'h0);
        apb(1'b1, `OFF_CTRL, 32'h0000_0200);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(rd[4], 1'b0);
        f(`CMD_SENS_REQ, SRES);
        f(4'hF, NONE);
        apb(1'b1, `OFF_CTRL, 32'h0000_0001);
        host_supply_pin <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk(rf_enabled, 1'b0);
        f(`CMD_ALL_REQ, NONE);
        host_supply_pin <= 1'b0;
        repeat (8) @(posedge clk);
        f(`CMD_ALL_REQ, SRES);
        f(4'hF, NONE);
        apb(1'b1, `OFF_CTRL, 32'h0000_0004);
        f(`CMD_ALL_REQ, NONE);
        apb(1'b1, `OFF_CTRL, 32'h0000_0008);
        repeat (2) @(posedge clk);
        #1;
        chk(tunnel_active, 1'b1);
        apb(1'b1, `OFF_CTRL, 32'h0000_000A);
        repeat (2) @(posedge clk);
        #1;
        chk(tunnel_active, 1'b0);
        apb(1'b1, `OFF_CTRL, 32'h0);
        apb(1'b1, `OFF_WAKE_EN, 32'h0000_0006);
        i = wakes;
        sel(`CMD_ALL_REQ);
        repeat (3) @(posedge clk);
        chk(wakes - i, 1);
        f(`CMD_SLP_REQ, NONE);
        repeat (3) @(posedge clk);
        chk(wakes - i, 2);
        conclude;
    end
endmodule // nfca_tag_state_machine_tb
